// *** hw/ldl_host_end.sv ***
`timescale 1ns/1ps
`include "ldl_consts.svh"

// Behaviour
// - host holds stop on all lanes initially
// - peripheral starts receiving, detects stop period
// - peripheral ignores link before period detected
// - peripheral ready immediately after detection
// - stop detector tolerates thirty percent error
// - host adds peripheral settle time
// - one shared clock for all lanes
// - one to four data lanes
// - byte k goes to lane k mod N
// - all active lanes start burst together
// - lane count fixed after initial configuration
// - multi-lane host runs with fewer lanes
// - clock stop follows last active lane
// - clock runs before start and after end
// - reverse data only lane 0, low power
// - lanes without bytes drop valid
// - short lanes end one slot earlier
// - receiver rebuilds original byte order

// Host end: power-up stop period, link clock and lane distributor.
module ldl_host_end import ldl_pkg::*; #(
  parameter logic [12:0] INIT_CYC = 13'(`LDL_HOST_INIT_CYC)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Static configuration, taken once after reset
  input wire logic [1:0] laneCfg,
  // Packet byte stream in
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast,
  output logic txReady,
  output logic linkReady,
  // Reverse bytes from the peripheral
  output logic [7:0] revByte,
  output logic revStrobe,
  // Link
  ldl_link_if.host link
);
  localparam logic [12:0] LEAD_SLOTS = 13'(`LDL_CLK_LEAD_SLOTS);
  localparam logic [12:0] TRAIL_SLOTS = 13'(`LDL_CLK_TRAIL_SLOTS);

  ldl_host_st_t q;
  ldl_host_st_t d;
  logic [`LDL_LANES-1:0] act;
  logic [`LDL_LANES-1:0] fillMask;
  logic slot;
  logic drain;
  logic ended;
  logic groupShort;

  // ****************************************************************
  // Lane masks
  // ****************************************************************
  // Lanes at or below the configured count are active; the rest stay in
  // stop, which lets a wide host serve a narrower peripheral.
  genvar g;
  generate
    for (g = 0; g < `LDL_LANES; g++) begin : gMask
      assign act[g] = (2'(g) <= q.lanesM1);
      assign fillMask[g] = (3'(g) < q.grpCnt);
    end
  endgenerate

  // A byte slot ends on the core cycle before the link clock falls, so
  // lane outputs change together with the falling edge.
  assign slot = q.clkRun && (q.div == `LDL_DIV_LAST);
  assign groupShort = (q.grpCnt <= {1'b0, q.lanesM1});

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    drain = 1'b0;
    ended = 1'b0;
    txReady = 1'b0;
    d.revStrobe = 1'b0;

    // The lane count is caught once and never again.
    if (!q.cfgDone) begin
      d.cfgDone = 1'b1;
      d.lanesM1 = laneCfg;
    end

    // Divide by four; the one clock serves every lane.
    if (q.clkRun) begin
      d.div = q.div + 2'h1;
      d.linkClk = d.div[1];
    end else begin
      d.div = 2'h0;
      d.linkClk = 1'b0;
    end

    case (q.state)
      hInit: begin
        // Every lane rests in stop, active or not.
        d.stop = '1;
        d.valid = '0;
        if (q.cnt == INIT_CYC - 13'h1) begin
          d.state = hReady;
          d.cnt = 13'h0;
        end else begin
          d.cnt = q.cnt + 13'h1;
        end
      end
      hReady: begin
        // A buffered byte starts the clock ahead of any lane activity.
        if (q.grpCnt != 3'h0) begin
          d.clkRun = 1'b1;
          d.cnt = LEAD_SLOTS;
          d.state = hLead;
        end
      end
      hLead: begin
        if (slot) begin
          if (q.cnt == 13'h1) begin
            // Active lanes leave stop in the same slot.
            d.stop = ~act;
            d.valid = '0;
            d.state = hBegin;
          end else begin
            d.cnt = q.cnt - 13'h1;
          end
        end
      end
      hBegin: begin
        drain = slot;
      end
      hData: begin
        drain = slot;
      end
      hTail: begin
        if (slot) begin
          // Lanes that carried the last byte end now.
          d.stop = '1;
          d.valid = '0;
          d.cnt = TRAIL_SLOTS;
          d.state = hTrail;
        end
      end
      hTrail: begin
        // The clock keeps running past the end of the last lane.
        if (slot) begin
          if (q.cnt == 13'h1) begin
            d.clkRun = 1'b0;
            d.state = hReady;
          end else begin
            d.cnt = q.cnt - 13'h1;
          end
        end
      end
      default: begin
        d.state = hInit;
      end
    endcase

    // Send one buffered group, one byte per lane.
    if (drain) begin
      d.data = q.grp;
      d.valid = fillMask & act;
      // The last byte marks the end; an underrun ends the burst early.
      ended = q.grpLast || groupShort;
      if (ended) begin
        // Lanes with nothing left go back to stop a slot early.
        d.stop = ~(fillMask & act);
        d.state = hTail;
      end else begin
        d.state = hData;
      end
      d.grpCnt = 3'h0;
      d.grpLast = 1'b0;
    end

    // Fill the group; byte k lands in slot k mod N from lane 0 upward.
    txReady = (q.state != hInit) && (drain || (!q.grpLast && groupShort));
    if (txValid && txReady) begin
      d.grp[d.grpCnt[1:0]] = txData;
      d.grpCnt = d.grpCnt + 3'h1;
      d.grpLast = txLast;
    end

    // Reverse path arrives on lane 0 only; data settles before the toggle.
    d.revTog1 = link.revToggle;
    d.revTog2 = q.revTog1;
    d.revTog3 = q.revTog2;
    d.revD1 = link.revData;
    d.revD2 = q.revD1;
    if (q.revTog2 != q.revTog3) begin
      d.revByte = q.revD2;
      d.revStrobe = 1'b1;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Lanes come out of reset already in stop.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= '{state: hInit, stop: '1, default: '0};
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.linkClk = q.linkClk;
  assign link.laneStop = q.stop;
  assign link.laneValid = q.valid;
  assign link.laneData = q.data;
  assign linkReady = (q.state != hInit);
  assign revByte = q.revByte;
  assign revStrobe = q.revStrobe;
endmodule

// *** hw/ldl_periph_end.sv ***
`timescale 1ns/1ps
`include "ldl_consts.svh"

// Peripheral end: stop-period detection and the lane merger.
module ldl_periph_end import ldl_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Static configuration, taken once after reset
  input wire logic [1:0] laneCfg,
  // Merged byte stream
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxFirst,
  output logic rxEnd,
  output logic linkReady,
  // Reverse bytes toward the host
  input wire logic revValid,
  input wire logic [7:0] revByte,
  output logic revReady,
  // Link
  ldl_link_if.periph link
);
  ldl_periph_st_t q;
  ldl_periph_st_t d;
  logic [`LDL_LANES-1:0] act;
  logic allStop;
  logic initDone;
  logic rise;
  logic [1:0] sel;

  // ****************************************************************
  // Active lanes and link state
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `LDL_LANES; g++) begin : gAct
      assign act[g] = (2'(g) <= q.lanesM1);
    end
  endgenerate

  // Decisions use the second synchroniser stage; the clock edge also compares it with the third.
  assign allStop = &(q.stop2 | ~act);
  assign rise = q.clk2 & ~q.clk3;

  // Stop state held long enough on every active lane opens the link.
  ldl_stop_timer u_ldl_stop_timer (
    .core_clk(core_clk),
    .reset(reset),
    .level(allStop),
    .done(initDone)
  );

  // ****************************************************************
  // Merger and reverse path
  // ****************************************************************
  always_comb begin
    d = q;
    sel = 2'h0;
    d.rxValid = 1'b0;
    d.rxFirst = 1'b0;
    d.rxEnd = 1'b0;
    if (!q.cfgDone) begin
      d.cfgDone = 1'b1;
      d.lanesM1 = laneCfg;
    end
    // Everything from the link passes two flops first.
    d.clk1 = link.linkClk;
    d.clk2 = q.clk1;
    d.clk3 = q.clk2;
    d.stop1 = link.laneStop;
    d.stop2 = q.stop1;
    d.valid1 = link.laneValid;
    d.valid2 = q.valid1;
    d.data1 = link.laneData;
    d.data2 = q.data1;
    case (q.state)
      pWait: begin
        if (initDone) begin
          d.state = pIdle;
        end
      end
      pIdle: begin
        if (rise && !allStop) begin
          d.state = pBurst;
          d.first = 1'b1;
        end
      end
      pBurst: begin
        if (rise) begin
          if (allStop) begin
            d.state = pIdle;
            d.rxEnd = 1'b1;
          end else begin
            d.grp = q.data2;
            d.pend = q.valid2 & act & ~q.stop2;
          end
        end
      end
      default: d.state = pWait;
    endcase
    // Lowest pending lane goes first, which restores the sent byte order.
    if (d.pend != '0) begin
      if (d.pend[0]) begin
        sel = 2'h0;
      end else if (d.pend[1]) begin
        sel = 2'h1;
      end else if (d.pend[2]) begin
        sel = 2'h2;
      end else begin
        sel = 2'h3;
      end
      d.rxData = d.grp[sel];
      d.rxValid = 1'b1;
      d.rxFirst = q.first;
      d.first = 1'b0;
      d.pend[sel] = 1'b0;
    end
    // Reverse bytes only on lane 0 while the lanes rest in stop.
    revReady = (q.state == pIdle) && allStop && (q.revWait == 2'h0);
    if (q.revWait != 2'h0) begin
      d.revWait = q.revWait - 2'h1;
      if (q.revWait == 2'h3) begin
        d.revToggle = ~q.revToggle;
      end
    end
    if (revValid && revReady) begin
      d.revData = revByte;
      d.revWait = 2'h3;
    end
  end

  // State register.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= '{state: pWait, default: '0};
    end else begin
      q <= d;
    end
  end

  assign rxData = q.rxData;
  assign rxValid = q.rxValid;
  assign rxFirst = q.rxFirst;
  assign rxEnd = q.rxEnd;
  assign linkReady = (q.state != pWait);
  assign link.revData = q.revData;
  assign link.revToggle = q.revToggle;
endmodule

// *** hw/ldl_stop_timer.sv ***
`timescale 1ns/1ps
`include "ldl_consts.svh"

// Counts consecutive core cycles of a level and latches done once the
// level has held for the detect count; done stays until reset.
module ldl_stop_timer import ldl_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Level to watch and result
  input wire logic level,
  output logic done
);
  localparam logic [11:0] DETECT_LAST = 12'(`LDL_DETECT_CYC - 1);

  ldl_timer_st_t q;
  ldl_timer_st_t d;

  // A break in the level restarts the count, so only an unbroken period counts.
  always_comb begin
    d = q;
    if (!q.done) begin
      if (!level) begin
        d.cnt = 12'h000;
      end else if (q.cnt == DETECT_LAST) begin
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt + 12'h001;
      end
    end
  end

  // State register.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;
endmodule

// *** shared/ldl_consts.svh ***
`ifndef LDL_CONSTS_SVH
`define LDL_CONSTS_SVH

// ****************************************************************
// Lane geometry
// ****************************************************************
// Most data lanes that either end is built for.
`define LDL_LANES 4
// Byte width of one lane slot.
`define LDL_BYTE_W 8

// ****************************************************************
// Clock and link timing
// ****************************************************************
// Core clock rate in MHz.
`define LDL_CLK_MHZ 40
// Value of the link divider in the core cycle before the link clock falls.
`define LDL_DIV_LAST 2'h3
// Nominal stop period after power-on, in microseconds.
`define LDL_INIT_US 100
// Extra settle time the peripheral asks for, in microseconds.
`define LDL_SETTLE_US 20
// Tolerance of the peripheral stop detector, in percent.
`define LDL_TOL_PCT 30
// Host drives the stop state for the stop period plus the settle time.
`define LDL_HOST_INIT_CYC ((`LDL_INIT_US + `LDL_SETTLE_US) * `LDL_CLK_MHZ)
// Peripheral accepts a stop period that is short by the full tolerance.
`define LDL_DETECT_CYC (`LDL_INIT_US * `LDL_CLK_MHZ * (100 - `LDL_TOL_PCT) / 100)
// Link byte slots of running clock before the first lane leaves stop.
`define LDL_CLK_LEAD_SLOTS 2
// Link byte slots of running clock after the last lane is back in stop.
`define LDL_CLK_TRAIL_SLOTS 2

`endif

// *** shared/ldl_link_if.sv ***
`timescale 1ns/1ps
`include "ldl_consts.svh"

// Link between the two ends: one shared clock, per-lane stop, valid and
// byte, and the reverse byte path that only lane 0 carries.
interface ldl_link_if;
  logic linkClk;
  logic [`LDL_LANES-1:0] laneStop;
  logic [`LDL_LANES-1:0] laneValid;
  logic [`LDL_LANES-1:0][`LDL_BYTE_W-1:0] laneData;
  logic [7:0] revData;
  logic revToggle;

  modport host (
    output linkClk,
    output laneStop,
    output laneValid,
    output laneData,
    input revData,
    input revToggle
  );

  modport periph (
    input linkClk,
    input laneStop,
    input laneValid,
    input laneData,
    output revData,
    output revToggle
  );
endinterface

// *** shared/ldl_pkg.sv ***
`include "ldl_consts.svh"

package ldl_pkg;

  // ****************************************************************
  // Shared types
  // ****************************************************************
  typedef logic [`LDL_LANES-1:0][`LDL_BYTE_W-1:0] ldl_lane_bytes_t;

  typedef enum logic [2:0] {hInit, hReady, hLead, hBegin, hData, hTail, hTrail} ldl_hstate_t;
  typedef enum logic [1:0] {pWait, pIdle, pBurst} ldl_pstate_t;

  // Whole state of the host end.
  typedef struct packed {
    ldl_hstate_t state;
    logic [12:0] cnt;
    logic cfgDone;
    logic [1:0] lanesM1;
    logic clkRun;
    logic [1:0] div;
    logic linkClk;
    logic [`LDL_LANES-1:0] stop;
    logic [`LDL_LANES-1:0] valid;
    ldl_lane_bytes_t data;
    ldl_lane_bytes_t grp;
    logic [2:0] grpCnt;
    logic grpLast;
    logic revTog1;
    logic revTog2;
    logic revTog3;
    logic [7:0] revD1;
    logic [7:0] revD2;
    logic [7:0] revByte;
    logic revStrobe;
  } ldl_host_st_t;

  // Whole state of the peripheral end.
  typedef struct packed {
    ldl_pstate_t state;
    logic cfgDone;
    logic [1:0] lanesM1;
    logic clk1;
    logic clk2;
    logic clk3;
    logic [`LDL_LANES-1:0] stop1;
    logic [`LDL_LANES-1:0] stop2;
    logic [`LDL_LANES-1:0] valid1;
    logic [`LDL_LANES-1:0] valid2;
    ldl_lane_bytes_t data1;
    ldl_lane_bytes_t data2;
    ldl_lane_bytes_t grp;
    logic [`LDL_LANES-1:0] pend;
    logic first;
    logic [7:0] rxData;
    logic rxValid;
    logic rxFirst;
    logic rxEnd;
    logic [1:0] revWait;
    logic [7:0] revData;
    logic revToggle;
  } ldl_periph_st_t;

  // State of the stop-period timer.
  typedef struct packed {
    logic [11:0] cnt;
    logic done;
  } ldl_timer_st_t;

endpackage

// *** tb/lane_distribution_and_link_init_tb.sv ***
`timescale 1ns/1ps
`include "ldl_consts.svh"

// ****************************************************************
// Bench for the host and peripheral ends
// ****************************************************************
module lane_distribution_and_link_init_tb import ldl_pkg::*;;
  localparam int INIT = 3000;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] laneCfg = 2'h3;
  logic txValid = 1'b0;
  logic [7:0] txData = 8'h00;
  logic txLast = 1'b0;
  logic revValid = 1'b0;
  logic [7:0] pRevByte = 8'h00;
  logic txReady, hReady, hRevStrobe, rxValid, rxFirst, rxEnd, pReady, revReady;
  logic [7:0] hRevByte, rxData;
  logic clkSeen = 1'b0;
  logic [7:0] expQ[$], rxQ[$], wireQ[$], revQ[$];
  int fails = 0, comparisons = 0, firsts = 0, ends = 0, pkts = 0;

  ldl_link_if link ();
  ldl_host_end #(.INIT_CYC(13'(INIT))) u_ldl_host_end (.core_clk(core_clk), .reset(reset),
    .laneCfg(laneCfg), .txValid(txValid), .txData(txData), .txLast(txLast),
    .txReady(txReady), .linkReady(hReady), .revByte(hRevByte), .revStrobe(hRevStrobe),
    .link(link));
  ldl_periph_end u_ldl_periph_end (.core_clk(core_clk), .reset(reset), .laneCfg(laneCfg),
    .rxData(rxData), .rxValid(rxValid), .rxFirst(rxFirst), .rxEnd(rxEnd), .linkReady(pReady),
    .revValid(revValid), .revByte(pRevByte), .revReady(revReady), .link(link));
  ldl_link_assertions #(.INIT_CYC(INIT)) u_ldl_link_assertions (.core_clk(core_clk),
    .reset(reset), .linkClk(link.linkClk), .laneStop(link.laneStop),
    .laneValid(link.laneValid), .laneData(link.laneData), .revData(link.revData),
    .revToggle(link.revToggle));

  // Core clock, 25 ns period.
  always #12.5 core_clk = ~core_clk;

  // Record wire bytes at each link clock rise, lane 0 first, and the user-side results.
  // Sampling on the falling core edge sees outputs after they have settled.
  always @(negedge core_clk) begin
    clkSeen <= link.linkClk;
    if (link.linkClk === 1'b1 && clkSeen === 1'b0) begin
      for (int i = 0; i < 4; i++) begin
        if (link.laneValid[i] === 1'b1) wireQ.push_back(link.laneData[i]);
      end
    end
    if (rxValid === 1'b1) rxQ.push_back(rxData);
    if (rxFirst === 1'b1) firsts++;
    if (rxEnd === 1'b1) ends++;
    if (hRevStrobe === 1'b1) revQ.push_back(hRevByte);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The lane count only changes under reset, as both ends take it once afterwards.
  task automatic do_reset(input logic [1:0] cfg);
    int n;
    n = 0;
    @(posedge core_clk);
    #1;
    reset = 1'b1;
    laneCfg = cfg;
    expQ.delete();
    rxQ.delete();
    wireQ.delete();
    revQ.delete();
    {firsts, ends, pkts} = '0;
    repeat (20) @(posedge core_clk);
    #1;
    reset = 1'b0;
    while (hReady !== 1'b1 && n < 4000) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n == 2000) check(pReady, 0);
    end
    check(n, INIT);
    check(pReady, 1);
  endtask

  // Offer bytes one per cycle; each is held until txReady is seen high.
  task automatic send_packet(input int len);
    int w;
    for (int k = 0; k < len; k++) begin
      @(posedge core_clk);
      #1;
      txValid = 1'b1;
      txData = 8'(pkts * 16 + k);
      txLast = (k == len - 1);
      expQ.push_back(txData);
      w = 0;
      do begin
        @(negedge core_clk);
        w++;
      end while (txReady !== 1'b1 && w < 200);
    end
    pkts++;
  endtask

  task automatic wait_rx();
    int w;
    w = 0;
    @(posedge core_clk);
    #1;
    txValid = 1'b0;
    txLast = 1'b0;
    while (ends < pkts && w < 2000) begin
      @(posedge core_clk);
      w++;
    end
    repeat (20) @(posedge core_clk);
    check(rxQ.size(), expQ.size());
    check(wireQ.size(), expQ.size());
    foreach (expQ[i]) begin
      check(rxQ[i], expQ[i]);
      check(wireQ[i], expQ[i]);
    end
    check(firsts, pkts);
    check(ends, pkts);
  endtask

  task automatic send_reverse(input logic [7:0] v);
    int w;
    w = 0;
    @(posedge core_clk);
    #1;
    revValid = 1'b1;
    pRevByte = v;
    do begin
      @(negedge core_clk);
      w++;
    end while (revReady !== 1'b1 && w < 200);
    @(posedge core_clk);
    #1;
    revValid = 1'b0;
    pRevByte = ~v;
    repeat (20) @(posedge core_clk);
    check(revQ.size(), 1);
    check(revQ[0], v);
  endtask

  // Every lane count from four down to one, packets of 1, 5 and 9 bytes back to back.
  initial begin
    for (int cfg = 3; cfg >= 0; cfg--) begin
      do_reset(2'(cfg));
      send_packet(1);
      send_packet(5);
      send_packet(9);
      wait_rx();
      send_reverse(8'(8'ha5 + cfg));
    end
    print_verdict();
  end

  // Watchdog: about 40000 cycles, well above the expected 13000.
  initial begin
    #1000000;
    fails++;
    print_verdict();
  end
endmodule

// *** tb/ldl_link_assertions.sv ***
`timescale 1ns/1ps
`include "ldl_consts.svh"

// ****************************************************************
// Link checker
// ****************************************************************
module ldl_link_assertions #(
  parameter int INIT_CYC = 3000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Link signals
  input wire logic linkClk,
  input wire logic [`LDL_LANES-1:0] laneStop,
  input wire logic [`LDL_LANES-1:0] laneValid,
  input wire logic [`LDL_LANES-1:0][`LDL_BYTE_W-1:0] laneData,
  input wire logic [7:0] revData,
  input wire logic revToggle
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [15:0] age_q;

  // Cycles since reset; it saturates so a long run never wraps into the stop window.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      age_q <= '0;
    end else if (age_q != 16'hffff) begin
      age_q <= age_q + 16'h1;
    end
  end

  a_stop_at_power: assert property (age_q < INIT_CYC |-> laneStop == 4'hf)
    else $error("lane left stop during power-up");
  a_start_together: assert property ($changed(laneStop) && $past(laneStop) == 4'hf
    |-> laneStop inside {4'he, 4'hc, 4'h8, 4'h0} && laneValid == 4'h0)
    else $error("lanes did not start the burst together");
  a_clock_lead: assert property ((laneStop == 4'hf && !linkClk) [*4]
    |=> laneStop == 4'hf)
    else $error("lane left stop with the link clock idle");
  a_clock_trail: assert property ($rose(laneStop == 4'hf) |-> ##[1:4] $rose(linkClk))
    else $error("link clock stopped with the last lane");
  a_clock_in_burst: assert property (laneStop != 4'hf |-> ##[1:3] $changed(linkClk))
    else $error("link clock idle during a burst");
  a_valid_from_zero: assert property (laneValid inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
    else $error("valid lanes not contiguous from lane 0");
  a_valid_not_stop: assert property ((laneValid & laneStop) == 4'h0)
    else $error("valid on a lane in stop");
  a_short_lane_early: assert property ($rose(laneStop[1]) && !laneStop[0]
    |-> ##[1:4] $rose(laneStop[0]))
    else $error("lane 0 did not end one slot after lane 1");
  a_data_at_rise: assert property ($rose(linkClk)
    |-> $stable(laneData) && $stable(laneValid))
    else $error("lane signals moved at the link clock rise");
  a_rev_lane_idle: assert property ($changed(revToggle) |-> laneStop == 4'hf)
    else $error("reverse byte during a burst");
  a_rev_data_held: assert property ($changed(revToggle) |-> $stable(revData))
    else $error("reverse byte moved with its toggle");

  // Main scenarios: four-lane burst, short last group, reverse byte.
  c_four_lanes: cover property (laneValid == 4'hf);
  c_short_group: cover property (laneValid == 4'h1 && laneStop[1]);
  c_reverse: cover property ($changed(revToggle));
endmodule
